/* verilog/qtm_pkg.sv */
// Constants, field layouts and carrier types of the transceiver mode control.
// Assumes a single 25 MHz core clock and an APB master for software access.
//
// Contract
// - Coding select high enables encoder and decoder
// - Mode bits: 00 full, 01 tx, 10 rx
// - Standby enable low means low power
// - Per-lane loopback routes tx back to rx
// - Multipurpose output function chosen by management
// - Default function reports signalling type, 1=HSTL
// - Comma function shows K28.5 seen on lane
// - Pattern select inserts generator and checker everywhere
// - Pattern pass shown only once function enabled
// - Lockstep latches all lanes on lane A clocks
// - Chip reset recentres buffers, clears management flags
// - Alignment search enables comma detect and alignment
// - Undriven inputs read at documented pull levels
// - Without lockstep each lane uses own clock
// - Tenth bit used only with coding disabled
package qtm_pkg;

  localparam int LANES = 4;

  // ---------------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL  = 12'h000;
  localparam logic [11:0] ADDR_MF_SEL   = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
  localparam logic [11:0] ADDR_PINS     = 12'h014;

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int CTL_HSTL_BIT = 0;   // Signalling type in use
  localparam logic [31:0] CONTROL_RST  = 32'h0000_0001;
  localparam logic [7:0]  MF_SEL_RST   = 8'h00;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  // Interrupt status: [3:0] signal lost, [7:4] comma seen, [11:8] check fail
  localparam int IRQ_LOS_POS   = 0;
  localparam int IRQ_COMMA_POS = 4;
  localparam int IRQ_FAIL_POS  = 8;

  // Pull levels applied to undriven inputs
  localparam logic PULL_UP   = 1'b1;
  localparam logic PULL_DOWN = 1'b0;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    QTM_MF_SIGTYPE,
    QTM_MF_LOS,
    QTM_MF_COMMA,
    QTM_MF_PATTERN
  } qtm_mf_fn_t;

  typedef enum logic [1:0] {
    QTM_DIR_FULL,
    QTM_DIR_TX,
    QTM_DIR_RX
  } qtm_dir_t;

  // Static control pins after synchronisation
  typedef struct packed {
    logic             coding_select;
    logic [1:0]       operating_mode;
    logic             standby_enable;
    logic [LANES-1:0] serial_loopback_select;
    logic             selftest_pattern_select;
    logic             lane_lockstep_select;
    logic             alignment_search_select;
    logic             factory_test_select;
  } qtm_pins_t;

  // Per-lane status arriving from the datapath
  typedef struct packed {
    logic [LANES-1:0] signal_absent_flag;
    logic [LANES-1:0] alignment_char_seen;
    logic [LANES-1:0] pattern_check_pass;
  } qtm_lane_stat_t;

  // Datapath controls driven out
  typedef struct packed {
    logic             encoder_enable;
    logic             decoder_enable;
    logic             tx_enable;
    logic             rx_enable;
    logic             low_power;
    logic [LANES-1:0] loopback_enable;
    logic             pattern_gen_enable;
    logic             pattern_chk_enable;
    logic             tx_clk_from_lane_a;
    logic             rx_clk_from_lane_a;
    logic             align_enable;
    logic             tenth_bit_used;
    logic             recentre_buffers;
    logic             factory_test;
  } qtm_ctl_t;

endpackage

/* verilog/qtm_mode_control.sv */
// Mode control and multipurpose output logic of a four-lane transceiver.
// Assumes static control pins from the board, lane status from the
// datapath on the core clock, and an APB master as management access.
`timescale 1ns/1ps

module qtm_mode_control
  import qtm_pkg::*;
#(
  parameter int NLANES = LANES
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // Control pins: value and drive-present (undriven uses pull level)
  input  wire qtm_pins_t         i_pins,
  input  wire qtm_pins_t         i_pins_driven,
  input  wire logic              i_buffer_recentre_reset_n,
  input  wire logic              i_buffer_recentre_driven,
  // Lane status from datapath (core clock)
  input  wire qtm_lane_stat_t    i_lane_stat,
  input  wire logic              i_pattern_check_result_valid,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Outputs
  output qtm_ctl_t               o_ctl,
  output logic [NLANES-1:0]      o_lane_multipurpose_outputs,
  output logic                   o_irq
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    qtm_pins_t        s1;
    qtm_pins_t        s2;
    qtm_pins_t        s3;
    logic [2:0]       rst_sync;
    qtm_pins_t        pins;
    logic             recentre;
    logic [31:0]      control;
    logic [7:0]       mf_sel;
    logic [31:0]      irq_stat;
    logic [31:0]      irq_mask;
    logic [LANES-1:0] los_q;
    logic [LANES-1:0] comma_q;
    logic [LANES-1:0] pass_q;
    qtm_ctl_t         ctl;
    logic [LANES-1:0] mf;
    logic [31:0]      prdata;
    logic             pslverr;
    logic             irq;
  } qtm_state_t;

  qtm_state_t state_reg;
  qtm_state_t state_next;

  // ---------------------------------------------------------------------
  // Pull resolution
  // ---------------------------------------------------------------------
  // Undriven pins take the internal pull level before synchronising
  qtm_pins_t pulled;
  logic      rst_pin;

  always_comb begin
    pulled.coding_select = i_pins_driven.coding_select ?
      i_pins.coding_select : PULL_UP;
    pulled.standby_enable = i_pins_driven.standby_enable ?
      i_pins.standby_enable : PULL_UP;
    pulled.alignment_search_select =
      i_pins_driven.alignment_search_select ?
      i_pins.alignment_search_select : PULL_UP;
    pulled.operating_mode = i_pins.operating_mode &
      i_pins_driven.operating_mode;
    pulled.serial_loopback_select = i_pins.serial_loopback_select &
      i_pins_driven.serial_loopback_select;
    pulled.selftest_pattern_select = i_pins.selftest_pattern_select &
      i_pins_driven.selftest_pattern_select;
    pulled.lane_lockstep_select = i_pins.lane_lockstep_select &
      i_pins_driven.lane_lockstep_select;
    pulled.factory_test_select = i_pins.factory_test_select &
      i_pins_driven.factory_test_select;
    rst_pin = i_buffer_recentre_driven ?
      i_buffer_recentre_reset_n : PULL_UP;
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;
  logic [31:0] rd_val;
  logic [31:0] events;

  always_comb begin
    state_next = state_reg;
    apb_wr = i_psel & i_penable & i_pwrite;
    // Read data is captured at setup so it stands through the access cycle
    apb_rd = i_psel & ~i_penable & ~i_pwrite;
    addr_ok = 1'b1;
    rd_val = 32'h0000_0000;
    events = 32'h0000_0000;

    // Three-stage synchroniser; a change counts once stages 2 and 3 agree
    state_next.s1 = pulled;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.pins = state_reg.s3;
    end
    state_next.rst_sync = {state_reg.rst_sync[1:0], rst_pin};
    if (state_reg.rst_sync[2] == state_reg.rst_sync[1]) begin
      state_next.recentre = ~state_reg.rst_sync[2];
    end

    // Lane events set sticky bits; set wins over a same-cycle APB clear
    state_next.los_q = i_lane_stat.signal_absent_flag;
    state_next.comma_q = i_lane_stat.alignment_char_seen;
    state_next.pass_q = i_lane_stat.pattern_check_pass;
    events[IRQ_LOS_POS +: LANES] =
      i_lane_stat.signal_absent_flag & ~state_reg.los_q;
    events[IRQ_COMMA_POS +: LANES] =
      i_lane_stat.alignment_char_seen & ~state_reg.comma_q;
    if (i_pattern_check_result_valid) begin
      events[IRQ_FAIL_POS +: LANES] = ~i_lane_stat.pattern_check_pass;
    end

    // APB decode; accesses complete in the access cycle
    if (i_paddr == ADDR_CONTROL) begin
      rd_val = state_reg.control;
    end else if (i_paddr == ADDR_MF_SEL) begin
      rd_val = {24'h000000, state_reg.mf_sel};
    end else if (i_paddr == ADDR_STATUS) begin
      rd_val = {20'h00000, state_reg.pass_q, state_reg.comma_q,
                state_reg.los_q};
    end else if (i_paddr == ADDR_IRQ_STAT) begin
      rd_val = state_reg.irq_stat;
    end else if (i_paddr == ADDR_IRQ_MASK) begin
      rd_val = state_reg.irq_mask;
    end else if (i_paddr == ADDR_PINS) begin
      rd_val = {{(32 - $bits(qtm_pins_t)){1'b0}}, state_reg.pins};
    end else begin
      addr_ok = 1'b0;
    end

    if (apb_wr && addr_ok) begin
      if (i_paddr == ADDR_CONTROL) begin
        state_next.control = i_pwdata;
      end else if (i_paddr == ADDR_MF_SEL) begin
        state_next.mf_sel = i_pwdata[7:0];
      end else if (i_paddr == ADDR_IRQ_STAT) begin
        state_next.irq_stat = state_reg.irq_stat & ~i_pwdata;
      end else if (i_paddr == ADDR_IRQ_MASK) begin
        state_next.irq_mask = i_pwdata;
      end
    end
    state_next.irq_stat = state_next.irq_stat | events;
    if (apb_rd) begin
      state_next.prdata = addr_ok ? rd_val : 32'h0000_0000;
    end
    state_next.pslverr = i_psel & ~i_penable & (i_paddr != ADDR_CONTROL) &
      (i_paddr != ADDR_MF_SEL) & (i_paddr != ADDR_STATUS) &
      (i_paddr != ADDR_IRQ_STAT) & (i_paddr != ADDR_IRQ_MASK) &
      (i_paddr != ADDR_PINS);

    // Chip reset recentres buffers and clears management flags
    if (state_reg.recentre) begin
      state_next.irq_stat = 32'h0000_0000;
      state_next.mf_sel = MF_SEL_RST;
    end
    state_next.irq = |(state_next.irq_stat & state_reg.irq_mask);

    // Datapath control decode
    state_next.ctl.encoder_enable = state_reg.pins.coding_select;
    state_next.ctl.decoder_enable = state_reg.pins.coding_select;
    state_next.ctl.tenth_bit_used = ~state_reg.pins.coding_select;
    case (state_reg.pins.operating_mode)
      2'b01: begin
        state_next.ctl.tx_enable = 1'b1;
        state_next.ctl.rx_enable = 1'b0;
      end
      2'b10: begin
        state_next.ctl.tx_enable = 1'b0;
        state_next.ctl.rx_enable = 1'b1;
      end
      default: begin
        // Reserved code behaves as full transceiver
        state_next.ctl.tx_enable = 1'b1;
        state_next.ctl.rx_enable = 1'b1;
      end
    endcase
    state_next.ctl.low_power = ~state_reg.pins.standby_enable;
    state_next.ctl.loopback_enable =
      state_reg.pins.serial_loopback_select;
    state_next.ctl.pattern_gen_enable =
      state_reg.pins.selftest_pattern_select;
    state_next.ctl.pattern_chk_enable =
      state_reg.pins.selftest_pattern_select;
    // Low selects per-lane own clocks
    state_next.ctl.tx_clk_from_lane_a =
      state_reg.pins.lane_lockstep_select;
    state_next.ctl.rx_clk_from_lane_a =
      state_reg.pins.lane_lockstep_select;
    state_next.ctl.align_enable =
      state_reg.pins.alignment_search_select;
    state_next.ctl.recentre_buffers = state_reg.recentre;
    state_next.ctl.factory_test = state_reg.pins.factory_test_select;

    // Multipurpose output per lane, function from 2-bit field each
    for (int l = 0; l < LANES; l++) begin
      case (qtm_mf_fn_t'(state_reg.mf_sel[2*l +: 2]))
        QTM_MF_LOS: begin
          state_next.mf[l] = state_reg.los_q[l];
        end
        QTM_MF_COMMA: begin
          // Comma seen only counts while alignment search runs
          state_next.mf[l] = state_reg.comma_q[l] &
            state_reg.pins.alignment_search_select;
        end
        QTM_MF_PATTERN: begin
          state_next.mf[l] = state_reg.pass_q[l] &
            state_reg.pins.selftest_pattern_select;
        end
        default: begin
          state_next.mf[l] = state_reg.control[CTL_HSTL_BIT];
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_reg <= '0;
      // Idle level of the pulled-up pin, so no false recentre after reset
      state_reg.rst_sync <= {SYNC_STAGES{PULL_UP}};
      state_reg.control <= CONTROL_RST;
      state_reg.mf_sel <= MF_SEL_RST;
      state_reg.irq_mask <= IRQ_MASK_RST;
      state_reg.mf <= {LANES{CONTROL_RST[CTL_HSTL_BIT]}};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  assign o_prdata = state_reg.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = state_reg.pslverr & i_penable;
  assign o_ctl = state_reg.ctl;
  assign o_lane_multipurpose_outputs = state_reg.mf[NLANES-1:0];
  assign o_irq = state_reg.irq;

endmodule

/* testbench/qtm_mode_control_asserts.sv */
// Checker for the pin decode of the transceiver mode control.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module qtm_mode_control_asserts
  import qtm_pkg::*;
#(
  parameter int NLANES = LANES
) (
  input wire logic      i_clk,
  input wire logic      i_rst_b,
  input wire qtm_pins_t i_pins,
  input wire qtm_pins_t i_pins_driven,
  input wire logic      i_buffer_recentre_reset_n,
  input wire logic      i_buffer_recentre_driven,
  input wire logic      o_pready,
  input wire qtm_ctl_t  o_ctl
);
  qtm_pins_t up;
  qtm_pins_t ep;
  logic      er;
  // Undriven pins read as their pull level
  always_comb begin
    up = '0;
    up.coding_select = PULL_UP;
    up.standby_enable = PULL_UP;
    up.alignment_search_select = PULL_UP;
    ep = (i_pins & i_pins_driven) | (up & ~i_pins_driven);
    er = i_buffer_recentre_driven ? i_buffer_recentre_reset_n : PULL_UP;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ------------------------------------------------------------
  // Decode checks
  // ------------------------------------------------------------
  // Eight quiet cycles cover sync, accept and decode with margin
  sequence quiet;
    ($stable(ep) && $stable(er))[*8];
  endsequence
  chk_code_sel: assert property (quiet |->
    o_ctl.encoder_enable == ep.coding_select &&
    o_ctl.decoder_enable == ep.coding_select &&
    o_ctl.tenth_bit_used == !ep.coding_select) else $error("coding");
  chk_mode_dir: assert property (quiet |->
    (o_ctl.tx_enable == (ep.operating_mode != 2'b10) &&
     o_ctl.rx_enable == (ep.operating_mode != 2'b01))) else $error("mode");
  chk_standby_lp: assert property (quiet |->
    o_ctl.low_power == !ep.standby_enable) else $error("standby");
  chk_loop_lane: assert property (quiet |->
    o_ctl.loopback_enable == ep.serial_loopback_select) else $error("loop");
  chk_pattern_ins: assert property (quiet |->
    o_ctl.pattern_gen_enable == ep.selftest_pattern_select &&
    o_ctl.pattern_chk_enable == ep.selftest_pattern_select)
    else $error("pattern");
  chk_lockstep_clk: assert property (quiet |->
    o_ctl.tx_clk_from_lane_a == ep.lane_lockstep_select &&
    o_ctl.rx_clk_from_lane_a == ep.lane_lockstep_select)
    else $error("lockstep");
  chk_align_en: assert property (quiet |->
    o_ctl.align_enable == ep.alignment_search_select) else $error("align");
  chk_recentre_buf: assert property (quiet |->
    o_ctl.recentre_buffers == !er) else $error("recentre");
  chk_apb_ready: assert property (o_pready) else $error("pready low");
  cover property (quiet ##0 ep.selftest_pattern_select);
  cover property (quiet ##0 ep.operating_mode == 2'b11);
  cover property (o_ctl.recentre_buffers);
endmodule
bind qtm_mode_control qtm_mode_control_asserts #(.NLANES(NLANES)) chk_u (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(i_pins),
  .i_pins_driven(i_pins_driven),
  .i_buffer_recentre_reset_n(i_buffer_recentre_reset_n),
  .i_buffer_recentre_driven(i_buffer_recentre_driven),
  .o_pready(o_pready), .o_ctl(o_ctl));

/* testbench/qtm_board_model.sv */
// Board strapping model that drives the static control pins.
// Assumes the bench names the wanted levels and which pins are driven.
`timescale 1ns/1ps
module qtm_board_model
  import qtm_pkg::*;
(
  input  wire logic      i_clk,
  input  wire qtm_pins_t i_want,
  input  wire qtm_pins_t i_drive,
  input  wire logic      i_rc_n,
  input  wire logic      i_rc_drive,
  output qtm_pins_t      o_pins,
  output qtm_pins_t      o_driven,
  output logic           o_rc_n,
  output logic           o_rc_driven
);
  qtm_pins_t drv;
  // Factory test is left open so its pull holds it low
  always_comb begin
    drv = i_drive;
    drv.factory_test_select = 1'b0;
  end
  initial begin
    o_pins = '0;
    o_driven = '0;
    o_rc_n = 1'b1;
    o_rc_driven = 1'b1;
  end
  // Open lines toggle so a stale value can never pose as the pull
  always @(posedge i_clk) begin
    o_pins <= (i_want & drv) | (~o_pins & ~drv);
    o_driven <= drv;
    o_rc_n <= i_rc_drive ? i_rc_n : ~o_rc_n;
    o_rc_driven <= i_rc_drive;
  end
endmodule

/* testbench/tb.sv */
// Self-checking bench for the transceiver mode control.
// Assumes the board model on the pins and the bound checker.
`timescale 1ns/1ps
module tb
  import qtm_pkg::*;
;
  logic i_clk, i_rst_b, rc_n, rc_drv, rpin, rdrv, pcv, irq;
  logic psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  mf;
  qtm_pins_t   want, drive, pins, pdrv;
  qtm_lane_stat_t lane_stat;
  qtm_ctl_t    ctl;
  int          error_cnt, n_checks;
  qtm_board_model brd_u (.i_clk(i_clk), .i_want(want), .i_drive(drive),
    .i_rc_n(rc_n), .i_rc_drive(rc_drv), .o_pins(pins), .o_driven(pdrv),
    .o_rc_n(rpin), .o_rc_driven(rdrv));
  qtm_mode_control dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(pins),
    .i_pins_driven(pdrv), .i_buffer_recentre_reset_n(rpin),
    .i_buffer_recentre_driven(rdrv), .i_lane_stat(lane_stat),
    .i_pattern_check_result_valid(pcv), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_ctl(ctl),
    .o_lane_multipurpose_outputs(mf), .o_irq(irq));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic check(input logic [32:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rerr = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let an edge pass so the next setup never reassigns psel at once
    @(posedge i_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    check(mf, 4'hf, "mf default");
    apb(0, ADDR_CONTROL, 0);
    check(rdata, CONTROL_RST, "control");
    apb(1, ADDR_CONTROL, 0);
    cyc(2);
    check(mf, 4'h0, "sstl");
    apb(1, ADDR_CONTROL, 1);
    cyc(2);
    check(mf, 4'hf, "hstl");
    apb(0, 12'h0fc, 0);
    check({rerr, rdata}, 33'h1_0000_0000, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_pins();
    for (int m = 0; m < 4; m++) begin
      want <= {1'b0, m[1:0], 1'b1, 4'ha, 1'b1, 1'b1, 1'b0, 1'b0};
      cyc(8);
      check(ctl.tx_enable, m != 2, "tx");
      check(ctl.rx_enable, m != 1, "rx");
    end
    check({ctl.encoder_enable, ctl.tenth_bit_used}, 2'b01, "code");
    check(ctl.loopback_enable, 4'ha, "loop");
    check(ctl.pattern_chk_enable, 1'b1, "prbs");
    check(ctl.rx_clk_from_lane_a, 1'b1, "lock");
    drive <= '0;
    cyc(8);
    check(ctl, 17'h1_e008, "undriven");
    drive <= '1;
    want <= '0;
    cyc(8);
    check(ctl.low_power, 1'b1, "standby");
    $display("t_pins done");
  endtask
  task automatic t_mf();
    want <= {1'b1, 2'b00, 1'b1, 4'h0, 1'b1, 1'b0, 1'b1, 1'b0};
    lane_stat <= {4'h3, 4'h5, 4'h9};
    cyc(8);
    check(mf, 4'hf, "no pass yet");
    apb(1, ADDR_MF_SEL, 32'h55);
    cyc(3);
    check(mf, 4'h3, "los");
    apb(1, ADDR_MF_SEL, 32'hff);
    cyc(3);
    check(mf, 4'h9, "pass");
    apb(1, ADDR_MF_SEL, 32'h1b);
    cyc(3);
    check(mf, 4'h9, "mixed");
    apb(1, ADDR_MF_SEL, 32'haa);
    cyc(3);
    check(mf, 4'h5, "comma");
    want.alignment_search_select <= 1'b0;
    cyc(8);
    check(mf, 4'h0, "align off");
    $display("t_mf done");
  endtask
  task automatic t_irq();
    lane_stat <= '0;
    apb(1, ADDR_IRQ_STAT, 32'hfff);
    lane_stat <= {4'h1, 8'h0};
    cyc(4);
    check(irq, 1'b0, "masked");
    apb(0, ADDR_IRQ_STAT, 0);
    check(rdata, 32'h1, "stat");
    apb(1, ADDR_IRQ_MASK, 32'h1);
    cyc(2);
    check(irq, 1'b1, "irq on");
    apb(1, ADDR_IRQ_STAT, 32'h1);
    cyc(2);
    check(irq, 1'b0, "irq clear");
    lane_stat <= {4'h3, 8'h0};
    rc_n <= 1'b0;
    cyc(8);
    check(ctl.recentre_buffers, 1'b1, "recentre");
    rc_n <= 1'b1;
    cyc(8);
    apb(0, ADDR_IRQ_STAT, 0);
    check(rdata, 32'h0, "flags");
    apb(0, ADDR_MF_SEL, 0);
    check(rdata, 32'h0, "mf_sel");
    // Failed pattern check on lanes 0 and 1 sets their fail flags
    lane_stat <= {4'h3, 4'h0, 4'hc};
    pcv <= 1'b1;
    cyc(2);
    pcv <= 1'b0;
    apb(0, ADDR_IRQ_STAT, 0);
    check(rdata, 32'h300, "fail");
    $display("t_irq done");
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    finish_test();
  end
  initial begin
    {i_rst_b, psel, penable, pwrite, pcv, paddr, pwdata} = '0;
    {rc_n, rc_drv, drive} = '1;
    want = {1'b1, 2'b00, 1'b1, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0};
    lane_stat = '0;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    cyc(8);
    t_reset();
    t_pins();
    t_mf();
    t_irq();
    finish_test();
  end
endmodule
